// *** smb_params.svh ***
// Constants for the block-mode serial master: widths, depths, the select count, the receive timeout and the idle select value.
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH
`define SMB_WORD_W 16
`define SMB_FIFO_DEPTH 16
`define SMB_SEL_COUNT 8
`define SMB_SEL_W 3
`define SMB_LEN_W 4
`define SMB_DIV_W 8
`define SMB_LVL_W 5
`define SMB_RX_TIMEOUT 64
`define SMB_SEL_IDLE 8'hFF
`endif

// *** smb_pkg.sv ***
// Types shared by the block-mode serial master.
package smb_pkg;
    typedef enum logic [3:0] {
        SMB_IDLE = 4'h1,
        SMB_SHIFT = 4'h2,
        SMB_STALL = 4'h4,
        SMB_END = 4'h8
    } smb_state_t;
endpackage : smb_pkg

// *** smb_master.sv ***
// Block-mode serial master with transmit and receive queues, watermarks and eight selects.
`timescale 1ns/1ps
`include "smb_params.svh"
module smb_master #(
    parameter int WORD_W = `SMB_WORD_W,
    parameter int DEPTH = `SMB_FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_enable,
    input wire logic i_tx_hold_control,
    input wire logic i_hold_select_on_underrun,
    input wire logic i_cpol,
    input wire logic i_cpha,
    input wire logic [`SMB_LEN_W-1:0] i_word_len_m1,
    input wire logic [`SMB_SEL_W-1:0] i_sel_num,
    input wire logic [`SMB_DIV_W-1:0] i_clock_predivider,
    input wire logic [`SMB_DIV_W-1:0] i_bit_rate_divider,
    input wire logic [`SMB_LVL_W-1:0] i_rx_level_trigger,
    input wire logic [`SMB_LVL_W-1:0] i_tx_level_trigger,
    input wire logic i_tx_write,
    input wire logic [WORD_W-1:0] i_tx_data,
    input wire logic i_final_word_marker,
    input wire logic i_rx_read,
    input wire logic i_clear_tx,
    input wire logic i_clear_rx,
    input wire logic i_clear_overrun,
    input wire logic i_clear_timeout,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_mosi,
    output logic [`SMB_SEL_COUNT-1:0] o_sel_n,
    output logic [WORD_W-1:0] o_rx_data,
    output logic o_rx_fifo_has_data_flag,
    output logic o_tx_empty,
    output logic o_tx_full,
    output logic o_busy,
    output logic o_rx_level_irq,
    output logic o_tx_level_irq,
    output logic o_rx_overrun_irq,
    output logic o_rx_timeout_irq
);
    import smb_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = 2 * `SMB_DIV_W + 1;

    if (WORD_W < 4 || WORD_W > 16 || DEPTH < 2 || DEPTH > 16 || (1 << AW) != DEPTH) begin : g_param_check
        $error("smb_master: unsupported width or depth");
    end

    function automatic logic [AW:0] level_of(input logic [AW:0] wp, input logic [AW:0] rp);
        level_of = wp - rp;
    endfunction : level_of

    smb_state_t state;
    smb_state_t next_state;
    logic [WORD_W:0] tx_mem [DEPTH];
    logic [WORD_W-1:0] rx_mem [DEPTH];
    logic [AW:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [PW-1:0] ph_cnt;
    logic [WORD_W-1:0] shift_out, shift_in;
    logic [`SMB_LEN_W-1:0] bit_cnt;
    logic half;
    logic cur_final;
    logic [7:0] idle_cnt;
    logic [`SMB_SEL_W-1:0] frame_sel;

    wire [AW:0] tx_level = level_of(tx_wp, tx_rp);
    wire [AW:0] rx_level = level_of(rx_wp, rx_rp);
    wire tx_empty = tx_level == '0;
    wire tx_full = tx_level == (AW+1)'(DEPTH);
    wire rx_empty = rx_level == '0;
    wire rx_full = rx_level == (AW+1)'(DEPTH);
    // A bit period below two clocks cannot form a serial clock, so such settings run at two.
    wire [PW-1:0] raw_period = PW'(i_clock_predivider) * (PW'(i_bit_rate_divider) + PW'(8'h01));
    wire [PW-1:0] period = (raw_period < PW'(8'h02)) ? PW'(8'h02) : raw_period;
    wire [PW-1:0] first_half_end = (period >> 1) - PW'(8'h01);
    wire tick = half ? (ph_cnt == period - PW'(8'h01)) : (ph_cnt == first_half_end);
    wire last_bit = bit_cnt == '0;
    wire word_done = (state == SMB_SHIFT) && tick && half && last_bit;
    wire can_start = i_enable && !i_tx_hold_control && !tx_empty;
    wire load_word = (state == SMB_IDLE && can_start) || (state == SMB_STALL && can_start)
        || (word_done && !cur_final && can_start);
    wire rx_pop = i_rx_read && !rx_empty;
    wire rx_push = word_done;
    wire [WORD_W:0] tx_head = tx_mem[tx_rp[AW-1:0]];
    wire [WORD_W-1:0] rx_word = {shift_in[WORD_W-2:0], i_miso};
    wire [WORD_W-1:0] len_mask = {WORD_W{1'b1}} >> (WORD_W - 1 - i_word_len_m1);

    always_comb begin
        next_state = state;
        case (state)
            SMB_IDLE: begin
                if (can_start) begin
                    next_state = SMB_SHIFT;
                end
            end
            SMB_SHIFT: begin
                if (word_done) begin
                    if (cur_final || (!load_word && !i_hold_select_on_underrun)) begin
                        next_state = SMB_END;
                    end else if (!load_word) begin
                        next_state = SMB_STALL;
                    end
                end
            end
            SMB_STALL: begin
                if (load_word) begin
                    next_state = SMB_SHIFT;
                end
            end
            SMB_END: next_state = SMB_IDLE;
            default: next_state = SMB_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tx_wp <= '0;
            tx_rp <= '0;
        end else if (i_clk_en) begin
            if (i_clear_tx) begin
                tx_wp <= '0;
                tx_rp <= '0;
            end else begin
                if (i_tx_write && !tx_full) begin
                    tx_mem[tx_wp[AW-1:0]] <= {i_final_word_marker, i_tx_data};
                    tx_wp <= tx_wp + 1'b1;
                end
                if (load_word) begin
                    tx_rp <= tx_rp + 1'b1;
                end
            end
        end
    end

    // Reads pop even when a debugger is the reader; there is no side-effect-free peek.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rx_wp <= '0;
            rx_rp <= '0;
            o_rx_data <= '0;
        end else if (i_clk_en) begin
            if (i_clear_rx) begin
                rx_wp <= '0;
                rx_rp <= '0;
            end else begin
                if (rx_push && !rx_full) begin
                    rx_mem[rx_wp[AW-1:0]] <= shift_in & len_mask;
                    rx_wp <= rx_wp + 1'b1;
                end
                if (rx_pop) begin
                    o_rx_data <= rx_mem[rx_rp[AW-1:0]];
                    rx_rp <= rx_rp + 1'b1;
                end
            end
        end
    end

    // The engine advances only on cycles with i_clk_en high, so a low enable freezes a frame in place.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= SMB_IDLE;
            ph_cnt <= '0;
            half <= 1'b0;
            bit_cnt <= '0;
            shift_out <= '0;
            shift_in <= '0;
            cur_final <= 1'b0;
            frame_sel <= '0;
        end else if (i_clk_en) begin
            state <= next_state;
            if (state == SMB_IDLE && can_start) begin
                frame_sel <= i_sel_num;
            end
            if (state != SMB_SHIFT || (tick && half)) begin
                ph_cnt <= '0;
            end else begin
                ph_cnt <= ph_cnt + PW'(8'h01);
            end
            if (load_word) begin
                shift_out <= tx_head[WORD_W-1:0] << (WORD_W - 1 - i_word_len_m1);
                cur_final <= tx_head[WORD_W];
                bit_cnt <= i_word_len_m1;
                half <= 1'b0;
            end else if (state == SMB_SHIFT && tick) begin
                half <= !half;
                if (!half) begin
                    shift_in <= rx_word;
                end else begin
                    shift_out <= shift_out << 1;
                    bit_cnt <= bit_cnt - 1'b1;
                end
            end
        end
    end

    // Overrun and timeout are sticky; a set in the clearing cycle wins.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rx_overrun_irq <= 1'b0;
            o_rx_timeout_irq <= 1'b0;
            idle_cnt <= '0;
        end else if (i_clk_en) begin
            if (rx_push && rx_full) begin
                o_rx_overrun_irq <= 1'b1;
            end else if (i_clear_overrun) begin
                o_rx_overrun_irq <= 1'b0;
            end
            if (rx_empty || rx_pop || rx_push) begin
                idle_cnt <= '0;
            end else if (idle_cnt != 8'(`SMB_RX_TIMEOUT)) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
            if (idle_cnt == 8'(`SMB_RX_TIMEOUT) - 8'h01) begin
                o_rx_timeout_irq <= 1'b1;
            end else if (i_clear_timeout) begin
                o_rx_timeout_irq <= 1'b0;
            end
        end
    end

    assign o_sclk = i_cpol ^ (state == SMB_SHIFT && (half ^ i_cpha));
    assign o_mosi = shift_out[WORD_W-1];
    assign o_sel_n = (state == SMB_IDLE) ? `SMB_SEL_IDLE : ~(8'h01 << frame_sel);
    assign o_busy = state != SMB_IDLE;
    assign o_rx_fifo_has_data_flag = !rx_empty;
    assign o_tx_empty = tx_empty;
    assign o_tx_full = tx_full;
    assign o_rx_level_irq = (i_rx_level_trigger != '0) && (rx_level >= i_rx_level_trigger);
    assign o_tx_level_irq = (i_tx_level_trigger != '0) && (tx_level < i_tx_level_trigger);
endmodule : smb_master

// *** smb_slave_model.sv ***
// Behavioural serial slave that answers each bit with its inverse.
`timescale 1ns/1ps
module smb_slave_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_sel_n,
    input wire logic i_mosi,
    output logic o_miso
);
    logic tgl = 1'b0;
    always @(posedge i_ref_clk) tgl <= ~tgl;
    // Deselected, the line toggles so a stale bit never passes as data.
    assign o_miso = (&i_sel_n) ? tgl : ~i_mosi;
endmodule : smb_slave_model

// *** smb_master_sva.sv ***
// Port checks for the block-mode serial master.
`timescale 1ns/1ps
module smb_master_sva (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_tx_hold_control,
    input wire logic i_cpol,
    input wire logic i_cpha,
    input wire logic [7:0] i_clock_predivider,
    input wire logic [7:0] i_bit_rate_divider,
    input wire logic [4:0] i_rx_level_trigger,
    input wire logic [4:0] i_tx_level_trigger,
    input wire logic i_rx_read,
    input wire logic i_clear_rx,
    input wire logic i_clear_overrun,
    input wire logic i_clear_timeout,
    input wire logic o_sclk,
    input wire logic [7:0] o_sel_n,
    input wire logic o_rx_fifo_has_data_flag,
    input wire logic o_tx_empty,
    input wire logic o_busy,
    input wire logic o_rx_level_irq,
    input wire logic o_tx_level_irq,
    input wire logic o_rx_overrun_irq,
    input wire logic o_rx_timeout_irq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    logic [15:0] hi_cnt;
    always_ff @(posedge i_ref_clk) begin
        if (i_clk_en) begin
            hi_cnt <= o_sclk ? hi_cnt + 16'h1 : 16'h0;
        end
    end
    wire [16:0] prod = 17'(i_clock_predivider) * (17'(i_bit_rate_divider) + 17'h00001);
    wire [16:0] per = (prod < 17'h00002) ? 17'h00002 : prod;
    wire [15:0] act_len = i_cpha ? 16'(per >> 1) : 16'(per - (per >> 1));
    sel_one_a: assert property ($onehot(~o_sel_n) || o_sel_n == 8'hFF) else $error("select not one-hot");
    idle_sel_a: assert property (!o_busy |-> o_sel_n == 8'hFF) else $error("select while idle");
    hold_start_a: assert property (i_tx_hold_control && !o_busy |=> !o_busy) else $error("start under hold");
    flag_drop_a: assert property ($fell(o_rx_fifo_has_data_flag) |-> $past(i_rx_read) || $past(i_clear_rx))
        else $error("receive data lost");
    rx_irq_a: assert property (i_rx_level_trigger != 5'h00 && !o_rx_fifo_has_data_flag |-> !o_rx_level_irq)
        else $error("receive watermark");
    tx_irq_a: assert property (i_tx_level_trigger == 5'h01 |-> o_tx_level_irq == o_tx_empty) else $error("tx mark");
    ovr_keep_a: assert property (o_rx_overrun_irq && !i_clear_overrun |=> o_rx_overrun_irq) else $error("ovr");
    tmo_keep_a: assert property (o_rx_timeout_irq && !i_clear_timeout |=> o_rx_timeout_irq) else $error("tmo");
    sclk_high_a: assert property ($fell(o_sclk) && !i_cpol && $past(i_cpol) == 1'b0 |-> hi_cnt == act_len)
        else $error("serial clock high time");
    busy_c: cover property ($rose(o_busy));
    stall_c: cover property (o_busy && o_tx_empty);
    ovr_c: cover property ($rose(o_rx_overrun_irq));
endmodule : smb_master_sva

// *** tb_top.sv ***
// Self-checking bench for the block-mode serial master.
`timescale 1ns/1ps
module tb_top;
    logic i_ref_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, i_enable = 1'b0, i_tx_hold_control = 1'b1;
    logic i_hold_select_on_underrun = 1'b0, i_cpol = 1'b0, i_cpha = 1'b0, i_tx_write = 1'b0, i_final_word_marker = 1'b0;
    logic i_rx_read = 1'b0, i_clear_tx = 1'b0, i_clear_rx = 1'b0, i_clear_overrun = 1'b0, i_clear_timeout = 1'b0;
    logic rd_d = 1'b0;
    logic [15:0] frz;
    logic [3:0] i_word_len_m1 = 4'hF;
    logic [2:0] i_sel_num = 3'h0;
    logic [7:0] i_clock_predivider = 8'h01, i_bit_rate_divider = 8'h00, o_sel_n;
    logic [4:0] i_rx_level_trigger = 5'h08, i_tx_level_trigger = 5'h01;
    logic [15:0] i_tx_data = 16'h0000, o_rx_data;
    logic [15:0] q[$], sent[$];
    logic i_miso, o_sclk, o_mosi, o_rx_fifo_has_data_flag, o_tx_empty, o_tx_full, o_busy;
    logic o_rx_level_irq, o_tx_level_irq, o_rx_overrun_irq, o_rx_timeout_irq;
    integer err_count = 0, num_checks = 0, seed = 32'h8CD29394;
    always #5 i_ref_clk = ~i_ref_clk;
    smb_master u_smb_master (.*);
    smb_slave_model u_smb_slave_model (.i_ref_clk, .i_sel_n(o_sel_n), .i_mosi(o_mosi), .o_miso(i_miso));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task automatic push(input logic f);
        i_tx_data = 16'($random(seed));
        i_final_word_marker = f;
        sent.push_back(~i_tx_data);
        i_tx_write = 1'b1;
        @(negedge i_ref_clk);
        i_tx_write = 1'b0;
    endtask : push
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 20000 && o_busy !== lvl; n++)
            @(negedge i_ref_clk);
        if (o_busy !== lvl) begin
            err_count++;
            finish_test();
        end
    endtask : wait_busy
    task automatic rd_n(input int n);
        repeat (n) begin
            i_rx_read = 1'b1;
            @(negedge i_ref_clk);
            i_rx_read = 1'b0;
            @(negedge i_ref_clk);
        end
    endtask : rd_n
    // Read data lands one edge after the pop, so compare on the next falling edge.
    always @(posedge i_ref_clk) rd_d <= i_rx_read;
    always @(negedge i_ref_clk) begin
        if (rd_d)
            chk(o_rx_data, q.pop_front());
    end
    initial begin
        repeat (20) @(negedge i_ref_clk);
        i_reset = 1'b0;
        i_enable = 1'b1;
        for (int s = 0; s < 8; s++) begin
            i_sel_num = 3'(s);
            i_clock_predivider = 8'(1 + s % 3);
            i_bit_rate_divider = 8'(s % 2);
            {i_cpol, i_cpha} = 2'(s >> 1);
            push(1'b1);
            repeat (4) @(negedge i_ref_clk);
            chk(16'(o_busy), 16'h0000);
            i_tx_hold_control = 1'b0;
            wait_busy(1'b1);
            chk(16'(o_sel_n), {8'h00, ~(8'h01 << s)});
            wait_busy(1'b0);
            i_tx_hold_control = 1'b1;
            chk(16'(o_rx_level_irq), 16'(s == 7));
        end
        q = sent;
        sent.delete();
        i_clock_predivider = 8'h01;
        i_cpol = 1'b0;
        i_cpha = 1'b0;
        i_bit_rate_divider = 8'h00;
        for (int k = 0; k < 17; k++)
            push(k == 15);
        chk({o_busy, o_tx_full}, 16'h0001);
        i_tx_hold_control = 1'b0;
        wait_busy(1'b1);
        // A low clock enable must freeze the running frame, which then resumes and completes.
        i_clk_en = 1'b0;
        frz = {6'h00, o_sclk, o_mosi, o_sel_n};
        repeat (5) @(negedge i_ref_clk);
        chk({6'h00, o_sclk, o_mosi, o_sel_n}, frz);
        i_clk_en = 1'b1;
        wait_busy(1'b0);
        i_tx_hold_control = 1'b1;
        repeat (8) q.push_back(sent.pop_front());
        sent.delete();
        repeat (70) @(negedge i_ref_clk);
        chk({o_rx_overrun_irq, o_rx_timeout_irq, o_rx_fifo_has_data_flag}, 16'h0007);
        i_clear_overrun = 1'b1;
        i_clear_timeout = 1'b1;
        @(negedge i_ref_clk);
        i_clear_overrun = 1'b0;
        i_clear_timeout = 1'b0;
        chk({o_rx_overrun_irq, o_rx_timeout_irq}, 16'h0000);
        rd_n(16);
        chk(16'(o_rx_fifo_has_data_flag), 16'h0000);
        i_clear_rx = 1'b1;
        i_clear_tx = 1'b1;
        @(negedge i_ref_clk);
        i_clear_rx = 1'b0;
        i_clear_tx = 1'b0;
        i_hold_select_on_underrun = 1'b1;
        i_sel_num = 3'h5;
        push(1'b0);
        push(1'b0);
        i_tx_hold_control = 1'b0;
        wait_busy(1'b1);
        repeat (200) @(negedge i_ref_clk);
        chk({o_busy, o_tx_empty, o_tx_level_irq, o_sel_n}, 16'h07DF);
        push(1'b1);
        wait_busy(1'b0);
        q = sent;
        rd_n(3);
        finish_test();
    end
endmodule : tb_top
bind smb_master smb_master_sva u_smb_master_sva (.*);
